// ---- common/acsel_regs.vh ----
// Register offsets, field positions, reset values and clock select codes
`ifndef ACSEL_REGS_VH
`define ACSEL_REGS_VH
`define ACSEL_ADDR_W        8
`define ACSEL_OFF_REF_CTRL  8'h63
`define ACSEL_OFF_COL_SEL   8'h60
`define ACSEL_OFF_SRC_SEL   8'h61
`define ACSEL_OFF_STATUS    8'h62
`define ACSEL_RST_REF_CTRL  8'h00
`define ACSEL_RST_COL_SEL   8'h00
`define ACSEL_RST_SRC_SEL   8'h00
`define ACSEL_PWR_LSB       0
`define ACSEL_PWR_MSB       2
`define ACSEL_REF_LSB       3
`define ACSEL_REF_MSB       5
`define ACSEL_SRC_A_LSB     0
`define ACSEL_SRC_A_MSB     2
`define ACSEL_SRC_B_LSB     3
`define ACSEL_SRC_B_MSB     5
`define ACSEL_CSEL_FIX1     2'h0
`define ACSEL_CSEL_FIX2     2'h1
`define ACSEL_CSEL_ASA      2'h2
`define ACSEL_CSEL_ASB      2'h3
`define ACSEL_DIV_RATIO     4
`endif

// ---- rtl/acsel_top.v ----
// Analog column clock select, divide-by-four column clocks and reference control registers
`timescale 1ns/1ps
`include "acsel_regs.vh"

module acsel_top #(
  parameter NCOL = 4,
  parameter NSRC = 8
) (
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    wb_cyc_i,
  input  wire                    wb_stb_i,
  input  wire                    wb_we_i,
  input  wire [7:0]              wb_adr_i,
  input  wire [31:0]             wb_dat_i,
  input  wire [3:0]              wb_sel_i,
  output reg  [31:0]             wb_dat_o,
  output reg                     wb_ack_o,
  input  wire                    fixed_clk_one,
  input  wire                    fixed_clk_two,
  input  wire [NSRC-1:0]         digital_block_clk,
  output reg  [NCOL-1:0]         column_clk,
  output reg                     switched_cap_blocks,
  output reg  [1:0]              reference_power_level,
  output reg  [2:0]              analog_ground
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0]          ref_ctrl_q;
  reg  [7:0]          col_sel_q;
  reg  [7:0]          src_sel_q;
  wire                wb_req;
  wire                wb_wr;
  wire [2:0]          array_power_sel;
  reg  [31:0]         rd_d;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
  assign array_power_sel = ref_ctrl_q[`ACSEL_PWR_MSB:`ACSEL_PWR_LSB];

  always @(posedge clk) begin
    if (rst) begin
      ref_ctrl_q <= `ACSEL_RST_REF_CTRL;
      col_sel_q  <= `ACSEL_RST_COL_SEL;
      src_sel_q  <= `ACSEL_RST_SRC_SEL;
    end else if (wb_wr) begin
      if (wb_adr_i == `ACSEL_OFF_REF_CTRL) begin
        ref_ctrl_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == `ACSEL_OFF_COL_SEL) begin
        col_sel_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == `ACSEL_OFF_SRC_SEL) begin
        src_sel_q <= wb_dat_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux and ack
  always @* begin
    if (wb_adr_i == `ACSEL_OFF_REF_CTRL) begin
      rd_d = {24'h000000, ref_ctrl_q};
    end else if (wb_adr_i == `ACSEL_OFF_COL_SEL) begin
      rd_d = {24'h000000, col_sel_q};
    end else if (wb_adr_i == `ACSEL_OFF_SRC_SEL) begin
      rd_d = {24'h000000, src_sel_q};
    end else if (wb_adr_i == `ACSEL_OFF_STATUS) begin
      rd_d = 32'h00000000;
      rd_d[NCOL-1:0] = column_clk;
    end else begin
      rd_d = 32'h00000000;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_d : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and analog system clock sources
  reg  [NSRC+1:0]     s1_q;
  reg  [NSRC+1:0]     s2_q;
  reg  [NSRC+1:0]     s3_q;
  reg  [NSRC+1:0]     lvl_q;
  wire [NSRC-1:0]     dblk;
  wire                fix1;
  wire                fix2;
  wire                analog_sys_clk_a;
  wire                analog_sys_clk_b;

  always @(posedge clk) begin
    if (rst) begin
      s1_q  <= {(NSRC+2){1'b0}};
      s2_q  <= {(NSRC+2){1'b0}};
      s3_q  <= {(NSRC+2){1'b0}};
      lvl_q <= {(NSRC+2){1'b0}};
    end else begin
      s1_q  <= {fixed_clk_two, fixed_clk_one, digital_block_clk};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  assign dblk = lvl_q[NSRC-1:0];
  assign fix1 = lvl_q[NSRC];
  assign fix2 = lvl_q[NSRC+1];
  assign analog_sys_clk_a = dblk[src_sel_q[`ACSEL_SRC_A_MSB:`ACSEL_SRC_A_LSB]];
  assign analog_sys_clk_b = dblk[src_sel_q[`ACSEL_SRC_B_MSB:`ACSEL_SRC_B_LSB]];

  ////////////////////////////////////////////////////////////////////////
  // Per column select and divide by four
  wire [NCOL-1:0]     col_d;
  genvar c;
  generate
    for (c = 0; c < NCOL; c = c + 1) begin : g_col
      wire [1:0] fsel;
      reg        sel_clk;
      reg        prev_q;
      reg  [1:0] div_q;
      assign fsel = col_sel_q[2*c+1:2*c];
      always @* begin
        case (fsel)
          `ACSEL_CSEL_FIX1: sel_clk = fix1;
          `ACSEL_CSEL_FIX2: sel_clk = fix2;
          `ACSEL_CSEL_ASA:  sel_clk = analog_sys_clk_a;
          default:          sel_clk = analog_sys_clk_b;
        endcase
      end
      always @(posedge clk) begin
        if (rst) begin
          prev_q <= 1'b0;
          div_q  <= 2'h0;
        end else begin
          prev_q <= sel_clk;
          if (sel_clk & ~prev_q) begin
            div_q <= div_q + 2'h1;
          end
        end
      end
      assign col_d[c] = div_q[1];
    end
  endgenerate

  // One output flop per column, shared by all blocks of that column
  always @(posedge clk) begin
    if (rst) begin
      column_clk <= {NCOL{1'b0}};
    end else begin
      column_clk <= col_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array power decode
  always @(posedge clk) begin
    if (rst) begin
      switched_cap_blocks   <= 1'b0;
      reference_power_level <= 2'h0;
      analog_ground         <= 3'h0;
    end else begin
      analog_ground <= ref_ctrl_q[`ACSEL_REF_MSB:`ACSEL_REF_LSB];
      case (array_power_sel)
        3'h1: begin
          switched_cap_blocks   <= 1'b0;
          reference_power_level <= 2'h1;
        end
        3'h2: begin
          switched_cap_blocks   <= 1'b0;
          reference_power_level <= 2'h2;
        end
        3'h3: begin
          switched_cap_blocks   <= 1'b0;
          reference_power_level <= 2'h3;
        end
        3'h5: begin
          switched_cap_blocks   <= 1'b1;
          reference_power_level <= 2'h1;
        end
        default: begin
          switched_cap_blocks   <= 1'b0;
          reference_power_level <= 2'h0;
        end
      endcase
    end
  end

endmodule

// ---- test/acsel_src_model.sv ----
// Far-side clock sources with distinct slow periods
`timescale 1ns/1ps
module acsel_src_model (
  output logic       fixed_clk_one,
  output logic       fixed_clk_two,
  output logic [7:0] digital_block_clk
);
  logic [9:0] s;
  assign {digital_block_clk, fixed_clk_two, fixed_clk_one} = s;
  // Half periods of 6+g clk cycles, edges kept off the bench clock edges
  for (genvar g = 0; g < 10; g++) begin : src
    initial begin
      s[g] = 1'b0;
      #13;
      forever #(300 + 50 * g) s[g] = ~s[g];
    end
  end
endmodule

// ---- test/acsel_top_asserts.sv ----
// Bus and output checks for the column clock select block
`timescale 1ns/1ps
module acsel_chk #(
  parameter NCOL = 4
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  input wire logic [NCOL-1:0] column_clk,
  input wire logic            switched_cap_blocks,
  input wire logic [1:0]      reference_power_level,
  input wire logic [2:0]      analog_ground
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire rd = wb_ack_o && !wb_we_i;
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
  a_ground_copy: assert property (rd && wb_adr_i == 8'h63 |-> wb_dat_o[5:3] == analog_ground) else $error("gnd");
  a_power_off: assert property (rd && wb_adr_i == 8'h63 && wb_dat_o[1:0] == 2'h0
    |-> reference_power_level == 2'h0 && !switched_cap_blocks) else $error("power off");
  a_caps_low: assert property (switched_cap_blocks |-> reference_power_level == 2'h1) else $error("caps");
  a_status_col: assert property (rd && wb_adr_i == 8'h62 |-> wb_dat_o[NCOL-1:0] == $past(column_clk))
    else $error("status");
  a_reset_clear: assert property ($fell(rst) |-> column_clk == '0 && !wb_ack_o) else $error("reset");
  a_div_hold: assert property ($changed(column_clk[0]) |=> $stable(column_clk[0]) [*7]) else $error("div");
  cover property (rd && wb_adr_i == 8'h62);
  cover property (switched_cap_blocks);
  cover property ($rose(column_clk[3]));
endmodule
bind acsel_top acsel_chk #(.NCOL(NCOL)) acsel_chk_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .column_clk(column_clk), .switched_cap_blocks(switched_cap_blocks),
  .reference_power_level(reference_power_level), .analog_ground(analog_ground));

// ---- test/acsel_top_tb.sv ----
// Register access and column clock tests
`timescale 1ns/1ps
module acsel_top_tb;
  logic        clk = 0, rst = 1, req = 0, we = 0, ack, f1, f2, sc;
  logic [7:0]  adr = 0, dbc;
  logic [31:0] dat = 0, q, dat_o;
  logic [3:0]  sel = 4'hf, col;
  logic [1:0]  lvl;
  logic [2:0]  gnd;
  int          num_errors = 0, comparisons = 0, n;
  acsel_top acsel_top_i (.clk(clk), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .fixed_clk_one(f1), .fixed_clk_two(f2),
    .digital_block_clk(dbc), .column_clk(col), .switched_cap_blocks(sc), .reference_power_level(lvl),
    .analog_ground(gnd));
  acsel_src_model acsel_src_model_i (.fixed_clk_one(f1), .fixed_clk_two(f2), .digital_block_clk(dbc));
  initial forever #25 clk = ~clk;
  task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dat_o;
    req <= 1'b0;
  endtask
  // Clock cycles from one rising column edge to the next
  task per(input int c);
    n = 0;
    for (int k = 0; k < 4; k++)
      while (col[c] !== k[0]) begin
        @(posedge clk);
        n += k / 2;
      end
  endtask
  task stop_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(0, 8'h60, 0);
    chk(q, 0, "col_sel");
    for (int i = 0; i < 6; i++) begin
      wb(1, 8'h63, {2'h0, i[2:0], i[2:0]});
      wb(0, 8'h63, 0);
      chk(q, {i[2:0], i[2:0]}, "ref_ctrl");
      chk(sc, i == 5, "caps");
      chk(lvl, (i % 4 == 0) ? 0 : (i == 5) ? 1 : i, "ref_pwr");
      chk(gnd, i, "ground");
    end
    // Sources first: analog A from block 3, analog B from block 5
    wb(1, 8'h61, 8'h2b);
    wb(1, 8'h60, 8'he4);
    wb(0, 8'h60, 0);
    chk(q, 8'he4, "col_sel");
    // Write with byte lane 0 off must be ignored
    sel <= 4'he;
    wb(1, 8'h60, 8'h00);
    sel <= 4'hf;
    wb(0, 8'h60, 0);
    chk(q, 8'he4, "sel_mask");
    wb(0, 8'h62, 0);
    wb(0, 8'h70, 0);
    chk(q, 0, "unmapped");
    for (int c = 0; c < 4; c++) begin
      per(c);
      chk(n, 8 * ((c < 2) ? 6 + c : 2 * c + 7), "col_period");
    end
    stop_test;
  end
endmodule
